// *** hw/serial_encoder_trigger_control.sv ***
// Serial encoder control: register slave, link clock and read trigger.
//
// How it works
// - Writes to the control register are dropped unless the unlock key was written just before.
// - Control bits 31..24 hold the 8-bit clock divisor mantissa M.
// - Control bits 23..20 hold the exponent N that divides by a further 2^N.
// - The link clock runs at 100 MHz divided by (M+1) times 2^N, except that M and N both zero hold it low.
// - The intermediate clock that paces the trigger delay runs at the link clock rate, and every reference cycle when M and N both zero hold the link clock low.
// - Bit 17 picks the trigger clock, 0 for phase and 1 for servo.
// - Bit 16 picks the trigger edge, 0 for rising and 1 for falling.
// - Bits 15..8 give a delay of 0 to 255 intermediate cycles from edge to read start.
// - Bits 7..0 carry the protocol code and 0x0b selects the BiSS-C link framing.
module serial_encoder_trigger_control
   import enc_ctrl_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        phase_clock,
   input  wire logic        servo_clock,
   output logic             serial_clock,
   output logic             encoder_read_start,
   output logic             biss_c_active
);

   // ****************************************************************
   // Byte-strobe merge.
   // ****************************************************************
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                               input logic [31:0] new_val,
                                               input logic [3:0]  strb);
      logic [31:0] res;
      res = old_val;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = new_val[8*i +: 8];
         end
      end
      return res;
   endfunction : merge_bytes

   logic [31:0] ctrl_reg;
   logic [31:0] ctrl_next;
   logic        unlock_reg;
   logic        unlock_next;
   logic [3:0]  awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        aw_taken;
   logic        w_taken;
   logic        wr_fire;
   logic        ar_fire;
   logic        wr_ctrl;
   logic        wr_key;
   logic        wr_ok;
   logic        key_match;
   logic [31:0] rd_data;
   logic        rd_ok;
   logic [31:0] status_word;

   // ****************************************************************
   // AXI4-Lite write channel: address and data taken in either order.
   // ****************************************************************
   assign aw_taken  = s_axi_awvalid && s_axi_awready;
   assign w_taken   = s_axi_wvalid && s_axi_wready;
   // Both halves are held; the write completes once no answer is pending.
   assign wr_fire   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wr_ctrl   = wr_fire && (awaddr_reg == CTRL_OFFSET);
   assign wr_key    = wr_fire && (awaddr_reg == KEY_OFFSET);
   assign wr_ok     = (awaddr_reg == CTRL_OFFSET)
                      || (awaddr_reg == KEY_OFFSET);
   assign key_match = (wstrb_reg == 4'hf) && (wdata_reg == UNLOCK_KEY);

   // A control write consumes the unlock; a wrong key relocks.
   assign unlock_next = wr_key ? key_match
                               : (wr_ctrl ? 1'b0 : unlock_reg);
   // Reserved bits are stored as written; software keeps them zero.
   assign ctrl_next   = (wr_ctrl && unlock_reg)
                        ? merge_bytes(ctrl_reg, wdata_reg, wstrb_reg)
                        : ctrl_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         awaddr_reg    <= 4'h0;
         wdata_reg     <= 32'h00000000;
         wstrb_reg     <= 4'h0;
         ctrl_reg      <= CTRL_RESET;
         unlock_reg    <= 1'b0;
      end else begin
         ctrl_reg   <= ctrl_next;
         unlock_reg <= unlock_next;
         if (aw_taken) begin
            s_axi_awready <= 1'b0;
            awaddr_reg    <= s_axi_awaddr;
         end
         if (w_taken) begin
            s_axi_wready <= 1'b0;
            wdata_reg    <= s_axi_wdata;
            wstrb_reg    <= s_axi_wstrb;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // AXI4-Lite read channel.
   // ****************************************************************
   trig_state_e state_reg;
   trig_state_e state_next;

   assign status_word = {29'h0, biss_c_active, unlock_reg,
                         (state_reg == TRIG_WAIT)};
   assign ar_fire     = s_axi_arvalid && s_axi_arready;
   assign rd_ok       = (s_axi_araddr == CTRL_OFFSET)
                        || (s_axi_araddr == KEY_OFFSET)
                        || (s_axi_araddr == STATUS_OFFSET);
   // The key location reads as zero so the key never leaks back.
   assign rd_data     = (s_axi_araddr == CTRL_OFFSET)   ? ctrl_reg    :
                        (s_axi_araddr == STATUS_OFFSET) ? status_word :
                                                          32'h00000000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (ar_fire) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_data;
         s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ****************************************************************
   // Field decode.
   // ****************************************************************
   logic [7:0] mantissa;
   logic [3:0] exponent;
   logic       src_sel;
   logic       edge_sel;
   logic [7:0] delay_cnt_cfg;
   logic [7:0] proto_code;

   assign mantissa      = ctrl_reg[MANT_MSB:MANT_LSB];
   assign exponent      = ctrl_reg[EXP_MSB:EXP_LSB];
   assign src_sel       = ctrl_reg[SRC_BIT];
   assign edge_sel      = ctrl_reg[EDGE_BIT];
   assign delay_cnt_cfg = ctrl_reg[DELAY_MSB:DELAY_LSB];
   assign proto_code    = ctrl_reg[PROTO_MSB:PROTO_LSB];

   logic intermediate_tick;

   serial_clock_divider u_divider (
      .aclk              (aclk),
      .aresetn           (aresetn),
      .mantissa          (mantissa),
      .exponent          (exponent),
      .serial_clock      (serial_clock),
      .intermediate_tick (intermediate_tick)
   );

   // ****************************************************************
   // Trigger clock synchronisers: a change counts once stages 2 and 3 agree.
   // ****************************************************************
   logic [2:0] phase_sync_reg;
   logic [2:0] servo_sync_reg;
   logic       phase_level_reg;
   logic       servo_level_reg;
   logic       phase_level_next;
   logic       servo_level_next;
   logic       sel_old;
   logic       sel_new;
   logic       trig_edge;

   assign phase_level_next = (phase_sync_reg[1] == phase_sync_reg[2])
                             ? phase_sync_reg[2] : phase_level_reg;
   assign servo_level_next = (servo_sync_reg[1] == servo_sync_reg[2])
                             ? servo_sync_reg[2] : servo_level_reg;
   assign sel_old   = src_sel ? servo_level_reg : phase_level_reg;
   assign sel_new   = src_sel ? servo_level_next : phase_level_next;
   // Falling edge when selected, rising edge otherwise.
   assign trig_edge = edge_sel ? (sel_old && !sel_new)
                               : (!sel_old && sel_new);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_sync_reg  <= 3'h0;
         servo_sync_reg  <= 3'h0;
         phase_level_reg <= 1'b0;
         servo_level_reg <= 1'b0;
      end else begin
         phase_sync_reg  <= {phase_sync_reg[1:0], phase_clock};
         servo_sync_reg  <= {servo_sync_reg[1:0], servo_clock};
         phase_level_reg <= phase_level_next;
         servo_level_reg <= servo_level_next;
      end
   end

   // ****************************************************************
   // Delay from trigger edge to read start, in intermediate cycles.
   // ****************************************************************
   logic [7:0] delay_reg;
   logic [7:0] delay_next;
   logic       fire_next;
   logic       biss_sel;

   assign biss_sel = (proto_code == PROTO_BISS_C);

   // Only BiSS-C framing is built here; any other code holds the trigger
   // off rather than driving a link whose framing is unknown.
   always_comb begin
      state_next = state_reg;
      delay_next = delay_reg;
      fire_next  = 1'b0;
      case (state_reg)
         TRIG_IDLE: begin
            if (trig_edge && biss_sel) begin
               if (delay_cnt_cfg == 8'h00) begin
                  fire_next = 1'b1;
               end else begin
                  state_next = TRIG_WAIT;
                  delay_next = delay_cnt_cfg;
               end
            end
         end
         TRIG_WAIT: begin
            if (!biss_sel) begin
               state_next = TRIG_IDLE;
            end else if (intermediate_tick) begin
               delay_next = delay_reg - 8'h01;
               if (delay_reg == 8'h01) begin
                  state_next = TRIG_IDLE;
                  fire_next  = 1'b1;
               end
            end
         end
         default: begin
            state_next = TRIG_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg          <= TRIG_IDLE;
         delay_reg          <= 8'h00;
         encoder_read_start <= 1'b0;
         biss_c_active      <= 1'b0;
      end else begin
         state_reg          <= state_next;
         delay_reg          <= delay_next;
         encoder_read_start <= fire_next;
         biss_c_active      <= biss_sel;
      end
   end

endmodule : serial_encoder_trigger_control

// *** hw/enc_ctrl_pkg.sv ***
// Constants shared by the serial encoder trigger control block.
package enc_ctrl_pkg;

   // ****************************************************************
   // Register map (byte addresses on the AXI4-Lite bus).
   // ****************************************************************
   localparam logic [3:0]  CTRL_OFFSET     = 4'h0;
   localparam logic [3:0]  KEY_OFFSET      = 4'h4;
   localparam logic [3:0]  STATUS_OFFSET   = 4'h8;
   localparam logic [31:0] CTRL_RESET      = 32'h0f400000;
   // Unlock key value is arbitrary.
   localparam logic [31:0] UNLOCK_KEY      = 32'h5a5a00a5;

   // ****************************************************************
   // Control register fields.
   // ****************************************************************
   localparam int MANT_MSB     = 31;
   localparam int MANT_LSB     = 24;
   localparam int EXP_MSB      = 23;
   localparam int EXP_LSB      = 20;
   localparam int RSVD_MSB     = 19;
   localparam int RSVD_LSB     = 18;
   localparam int SRC_BIT      = 17;
   localparam int EDGE_BIT     = 16;
   localparam int DELAY_MSB    = 15;
   localparam int DELAY_LSB    = 8;
   localparam int PROTO_MSB    = 7;
   localparam int PROTO_LSB    = 0;
   localparam logic [7:0] PROTO_BISS_C = 8'h0b;

   // ****************************************************************
   // Status register fields and bus answers.
   // ****************************************************************
   localparam int ST_WAIT_BIT   = 0;
   localparam int ST_UNLOCK_BIT = 1;
   localparam int ST_BISS_BIT   = 2;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [0:0] {TRIG_IDLE, TRIG_WAIT} trig_state_e;

endpackage : enc_ctrl_pkg

// *** hw/serial_clock_divider.sv ***
// Mantissa and power-of-two divider making the link and intermediate clocks.
module serial_clock_divider
   import enc_ctrl_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [7:0] mantissa,
   input  wire logic [3:0] exponent,
   output logic            serial_clock,
   output logic            intermediate_tick
);

   logic [7:0]  mant_cnt_reg;
   logic [7:0]  mant_cnt_next;
   logic [14:0] pre_cnt_reg;
   logic [14:0] pre_cnt_next;
   logic [14:0] pre_mask;
   logic        mant_wrap;
   logic        period_end;
   logic        clk_next;

   // ****************************************************************
   // Count reference cycles to M, then through a 2^N prescaler.
   // ****************************************************************
   // A counter above M after a reprogram wraps at once instead of
   // running through 256 cycles.
   assign mant_wrap     = (mant_cnt_reg >= mantissa);
   assign mant_cnt_next = mant_wrap ? 8'h00 : mant_cnt_reg + 8'h01;
   assign pre_mask      = (15'h0001 << exponent) - 15'h0001;
   assign pre_cnt_next  = mant_wrap ? pre_cnt_reg + 15'h0001 : pre_cnt_reg;
   // One period is (M+1)*2^N reference cycles of 10 ns.
   assign period_end    = mant_wrap
                          && ((pre_cnt_reg & pre_mask) == pre_mask);

   // With N zero the high phase is the upper half of the mantissa count;
   // otherwise the top prescaler bit gives an even duty cycle.
   assign clk_next = (exponent == 4'h0) ? (mant_cnt_next > (mantissa >> 1))
                                        : pre_cnt_next[exponent - 4'h1];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mant_cnt_reg      <= 8'h00;
         pre_cnt_reg       <= 15'h0000;
         serial_clock      <= 1'b0;
         intermediate_tick <= 1'b0;
      end else begin
         mant_cnt_reg      <= mant_cnt_next;
         pre_cnt_reg       <= pre_cnt_next;
         serial_clock      <= clk_next;
         intermediate_tick <= period_end;
      end
   end

endmodule : serial_clock_divider

// *** bench/serial_encoder_trigger_control_asserts.sv ***
// Port checker for the serial encoder trigger control block.
module serial_encoder_trigger_control_asserts
   import enc_ctrl_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        encoder_read_start,
   input wire logic        biss_c_active
);
   // ****************************************************************
   // Single clock domain, so clocking and disable are shared.
   // ****************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Bus side: answers come in bounded time and stand until taken.
   chk_reset_idle: assert property ($rose(aresetn) |-> s_axi_awready &&
      s_axi_arready && !s_axi_bvalid && !s_axi_rvalid)
      else $error("bus not idle after reset");
   chk_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   chk_write_single: assert property (s_axi_bvalid |->
      !s_axi_awready && !s_axi_wready)
      else $error("second write taken");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid)
      else $error("read answer late");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");

   // Trigger side: the read start is a lone pulse and only for BiSS-C.
   chk_pulse_single: assert property (encoder_read_start |=>
      !encoder_read_start)
      else $error("read start pulse too long");
   chk_trig_biss: assert property (encoder_read_start |->
      biss_c_active)
      else $error("read start without BiSS-C");
endmodule : serial_encoder_trigger_control_asserts

bind serial_encoder_trigger_control serial_encoder_trigger_control_asserts
   u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .encoder_read_start, .biss_c_active);

// *** bench/encoder_link_model.sv ***
// Behavioural encoder at the far end of the link: measures the clock.
module encoder_link_model (
   input  wire logic aclk,
   input  wire logic serial_clock,
   output int        period
);
   timeunit 1ns;
   timeprecision 1ps;
   int   count = 0;
   logic last  = 1'b0;
   // Sampled on the reference clock so a period is whole reference cycles.
   always @(posedge aclk) begin
      count++;
      if (serial_clock === 1'b1 && last !== 1'b1) begin
         period <= count;
         count = 0;
      end
      last = serial_clock;
   end
endmodule : encoder_link_model

// *** bench/serial_encoder_trigger_control_tb_top.sv ***
// Self-checking bench for the serial encoder trigger control block.
module serial_encoder_trigger_control_tb_top
   import enc_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic phase_clock = 0, servo_clock = 0;
   logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, model_ctrl, rd_data;
   logic [1:0]  s_axi_bresp, s_axi_rresp, wr_resp, rd_resp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, serial_clock, encoder_read_start, biss_c_active;
   int n_errors = 0, comparisons = 0, period, n_pulse = 0, n_base = 0;
   logic [7:0] mant;
   logic [3:0] expo;
   logic [7:0] dly [3] = '{8'h00, 8'h01, 8'hff};

   always #5 aclk = ~aclk;
   // Pulses are counted off the sampling edge to stay race free.
   always @(negedge aclk) if (encoder_read_start === 1'b1) n_pulse++;

   serial_encoder_trigger_control u_serial_encoder_trigger_control (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .phase_clock, .servo_clock,
      .serial_clock, .encoder_read_start, .biss_c_active);
   encoder_link_model u_encoder_link_model (.aclk, .serial_clock, .period);

   task check(input logic [31:0] seen, input logic [31:0] exp, string m);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t %s: %h not %h", $time, m, seen, exp);
      end
   endtask : check

   task test_done;
      $display("compares %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done

   // Address and data are offered together and each dropped once taken.
   task axi_wr(input logic [3:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         t++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && t < 50);
      wr_resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (t >= 50) n_errors++;
   endtask : axi_wr

   task rd_check(input logic [3:0] a, input logic [31:0] e,
                 input logic [1:0] r);
      int t;
      t = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         t++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && t < 50);
      rd_data = s_axi_rdata;
      rd_resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      check(rd_data, e, "read data");
      check({30'h0, rd_resp}, {30'h0, r}, "read resp");
   endtask : rd_check

   // A control write lands only when the key went just before it.
   task wr_ctrl(input logic [31:0] d, input bit key);
      if (key) axi_wr(KEY_OFFSET, UNLOCK_KEY);
      axi_wr(CTRL_OFFSET, d);
      check({30'h0, wr_resp}, {30'h0, RESP_OKAY}, "write resp");
      if (key) model_ctrl = d;
      rd_check(CTRL_OFFSET, model_ctrl, RESP_OKAY);
   endtask : wr_ctrl

   // Wrong source first, then the chosen edge; latency is in reference cycles.
   task trig(input bit s, input bit e, input logic [7:0] d);
      int lat, n0, lo, hi;
      lat = 0;
      lo = (d == 0) ? 3 : (d - 1) * 4 + 3;
      hi = d * 4 + 8;
      wr_ctrl({8'h01, 4'h1, 2'b00, s, e, d, PROTO_BISS_C}, 1);
      check(biss_c_active, 1'b1, "biss active");
      phase_clock <= e;
      servo_clock <= e;
      repeat (8) @(posedge aclk);
      n0 = n_pulse;
      if (s) phase_clock <= ~e;
      else servo_clock <= ~e;
      repeat (hi + 4) @(posedge aclk);
      check(n_pulse, n0, "unselected source fired");
      if (s) servo_clock <= ~e;
      else phase_clock <= ~e;
      do begin
         @(posedge aclk);
         lat++;
      end while (encoder_read_start !== 1'b1 && lat < 1100);
      check(lat >= lo && lat <= hi, 1'b1, "trigger delay");
      repeat (8) @(posedge aclk);
      check(n_pulse, n0 + 1, "pulse count");
   endtask : trig

   initial begin
      void'($urandom(32'hee7a3d45));
      model_ctrl = CTRL_RESET;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd_check(CTRL_OFFSET, CTRL_RESET, RESP_OKAY);
      rd_check(KEY_OFFSET, 32'h0, RESP_OKAY);
      rd_check(4'hc, 32'h0, RESP_SLVERR);
      axi_wr(4'hc, 32'h0);
      check({30'h0, wr_resp}, {30'h0, RESP_SLVERR}, "bad write resp");
      $display("test reset_map done");
      wr_ctrl(32'h0110000b, 0);
      axi_wr(KEY_OFFSET, UNLOCK_KEY);
      rd_check(STATUS_OFFSET, 32'h2, RESP_OKAY);
      axi_wr(CTRL_OFFSET, 32'h0310000b);
      model_ctrl = 32'h0310000b;
      rd_check(CTRL_OFFSET, model_ctrl, RESP_OKAY);
      wr_ctrl(32'h0720000b, 0);
      // Only the delay byte is strobed, so the other bytes must survive.
      axi_wr(KEY_OFFSET, UNLOCK_KEY);
      s_axi_wstrb <= 4'h2;
      axi_wr(CTRL_OFFSET, 32'hffff5aff);
      s_axi_wstrb <= 4'hf;
      model_ctrl[15:8] = 8'h5a;
      rd_check(CTRL_OFFSET, model_ctrl, RESP_OKAY);
      $display("test write_lock done");
      // The divider is free running, so several periods pass first.
      for (int i = 0; i < 3; i++) begin
         mant = 8'($urandom_range(15, 1));
         expo = 4'($urandom_range(3, 0));
         wr_ctrl({mant, expo, 12'h000, PROTO_BISS_C}, 1);
         repeat (((mant + 1) << expo) * 3 + 4) @(posedge aclk);
         check(period, (mant + 1) << expo, "link period");
      end
      $display("test link_clock done");
      for (int s = 0; s < 2; s++)
         for (int e = 0; e < 2; e++)
            for (int k = 0; k < 3; k++)
               trig(s[0], e[0], dly[k]);
      $display("test trigger done");
      wr_ctrl({8'h01, 4'h1, 12'h000, 8'h03}, 1);
      check(biss_c_active, 1'b0, "biss idle");
      phase_clock <= 1'b0;
      repeat (8) @(posedge aclk);
      n_base = n_pulse;
      check(n_base, 12, "trigger total");
      rd_check(STATUS_OFFSET, 32'h0, RESP_OKAY);
      phase_clock <= 1'b1;
      repeat (20) @(posedge aclk);
      check(n_pulse, n_base, "trigger with other protocol");
      $display("test protocol done");
      test_done();
   end

   // Expected run is about 10k cycles; this cuts a hang well beyond that.
   initial begin
      #400000;
      n_errors++;
      test_done();
   end
endmodule : serial_encoder_trigger_control_tb_top
